// >>> logic/spm_pkg.sv
`default_nettype none

package spm_pkg;

  // Raw pin vector positions, all passed through the pin synchroniser
  localparam int PIN_W = 21;
  localparam int DRV_W = 16;
  localparam int PIN_P93 = 0;
  localparam int PIN_P94 = 1;
  localparam int PIN_P95 = 2;
  localparam int PIN_P96 = 3;
  localparam int PIN_P97 = 4;
  localparam int PIN_P98 = 5;
  localparam int PIN_P99 = 6;
  localparam int PIN_P100 = 7;
  localparam int PIN_P43 = 8;
  localparam int PIN_P44 = 9;
  localparam int PIN_P45 = 10;
  localparam int PIN_P46 = 11;
  localparam int PIN_P48 = 12;
  localparam int PIN_BASE_LOW = 13;
  localparam int PIN_BASE_HIGH = 14;
  localparam int PIN_MODE = 15;
  localparam int PIN_BUSY = 16;
  localparam int PIN_TC = 17;
  localparam int PIN_DACK0 = 18;
  localparam int DACK_N = 3;

  // Host address path
  localparam int ADDR_W = 12;
  localparam int BASE_W = 11;
  localparam int SYNC_STAGES = 3;

  // Index and data port addresses
  localparam logic [11:0] PNP_INDEX_ADDR = 12'h279;
  localparam logic [11:0] PNP_WDATA_ADDR = 12'ha79;
  localparam logic [10:0] MB_BASE_LOW = 11'h15c;
  localparam logic [10:0] MB_BASE_HIGH = 11'h02e;

  // Values after reset
  localparam logic MODE_RST = 1'b0;
  localparam logic [10:0] BASE_RST = 11'h000;
  localparam logic PNP_RST = 1'b1;

  // Pin 43 alternate selections (two-UART mode only)
  localparam logic [1:0] SEL43_IRRX = 2'h0;
  localparam logic [1:0] SEL43_KBD = 2'h1;
  localparam logic [1:0] SEL43_RATE = 2'h2;

  typedef enum logic [2:0] {
    SPM_PH_STRAP = 3'b001,
    SPM_PH_LOAD = 3'b010,
    SPM_PH_RUN = 3'b100
  } spm_phase_e;

  // Captured strap levels
  typedef struct packed {
    logic mode_strap;
    logic base_strap_high;
    logic base_strap_low;
  } spm_strap_s;

  // Signals from the peripheral cores toward the pins
  typedef struct packed {
    logic uart_one_serial_out;
    logic uart_one_rts_n;
    logic uart_one_dtr_n;
    logic uart_two_serial_out;
    logic uart_two_rts_n;
    logic uart_two_dtr_n;
    logic infrared_transmit;
    logic [2:0] infrared_select;
    logic infrared_select_oe;
    logic floppy_rate_select;
    logic floppy_density_select;
    logic motor_select_zero_n;
    logic motor_select_one_n;
    logic drive_select_one_n;
    logic keyboard_port_bit;
  } spm_core_out_s;

  // Signals from the pins toward the peripheral cores
  typedef struct packed {
    logic uart_two_serial_in;
    logic uart_two_cts_n;
    logic uart_two_dcd_n;
    logic uart_two_dsr_n;
    logic uart_two_ri_n;
    logic infrared_receive_one;
    logic infrared_receive_two;
    logic [3:0] identification_input;
    logic keyboard_port_bit;
    logic addr_bit_eleven;
  } spm_core_in_s;

endpackage

`default_nettype wire

// >>> logic/spm_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser with agreement filter, one per bit
module spm_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input wire logic i_mclk,
  // Asynchronous levels
  input wire logic [WIDTH-1:0] i_async,
  // Filtered levels
  output logic [WIDTH-1:0] o_level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic meta_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // Chain left unreset so straps pass while reset is held
      always_ff @(posedge i_mclk) begin
        meta_r <= i_async[g];
        s2_r <= meta_r;
        s3_r <= s2_r;
      end
      // Accept a level once stages two and three agree
      always_ff @(posedge i_mclk) begin
        if (s2_r == s3_r) begin
          lvl_r <= s3_r;
        end
      end
      assign o_level[g] = lvl_r;
    end
  endgenerate

endmodule

`default_nettype wire

// >>> logic/spm_strap_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - The first UART serial output pin is read as the mode strap in reset and drives serial output afterwards.
// - Mode strap 0 gives the upper eight pins their infrared and misc roles, 1 gives them the second UART.
// - In second-UART mode the five lower pins keep defaults unless a configuration input picks an alternate.
// - The printer data strobe pin floats when its control bit is 0.
// - Outside enhanced mode the strobe pin drives the printer data strobe.
// - One pin carries printer data strobe or enhanced write strobe, chosen by port mode.
// - In enhanced mode the pin drives the active-low write strobe.
// - One input pin is busy status or enhanced wait, chosen by port mode.
// - Terminal count is ignored unless a DMA acknowledge is active.
// - Terminal count polarity is high or low as configuration selects.
// - Straps set part of the configuration and later configuration writes may change it.
// - Configuration registers are reached through an index port then a data port.
// - Index and data port addresses come from straps captured in reset.
// - The index and data ports may be relocated by an 11-bit base register.
// - The first UART request-to-send pin is read as the high base strap in reset.
module spm_strap_pin_mux (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Raw pins
  input wire logic [spm_pkg::PIN_W-1:0] i_pin,
  output logic [spm_pkg::DRV_W-1:0] o_pin_out,
  output logic [spm_pkg::DRV_W-1:0] o_pin_oe,
  // Peripheral cores
  input wire spm_pkg::spm_core_out_s i_core,
  output spm_pkg::spm_core_in_s o_core,
  // Lower pin alternates
  input wire logic [1:0] i_pin43_sel,
  input wire logic [3:0] i_lower_alt,
  // Configuration updates
  input wire logic i_mode_load,
  input wire logic i_mode_value,
  input wire logic i_base_load,
  input wire logic [spm_pkg::BASE_W-1:0] i_base_value,
  // Parallel port
  input wire logic i_pp_epp_mode,
  input wire logic i_pp_stb_enable,
  input wire logic i_pp_stb_n,
  input wire logic i_pp_write_n,
  output logic o_pp_stb_pin,
  output logic o_pp_stb_oe,
  output logic o_pp_busy,
  output logic o_pp_wait_n,
  output logic o_pp_extend,
  // DMA terminal count
  input wire logic i_tc_active_low,
  output logic o_tc_accepted,
  // Host address
  input wire logic [spm_pkg::ADDR_W-1:0] i_isa_addr,
  input wire logic i_isa_aen,
  output logic o_index_hit,
  output logic o_data_hit,
  output logic o_index_wr_only,
  // Configuration state
  output spm_pkg::spm_strap_s o_strap,
  output logic o_mode,
  output logic o_pnp_full,
  output logic [spm_pkg::BASE_W-1:0] o_base
);

  logic [spm_pkg::PIN_W-1:0] pin_s;
  logic [spm_pkg::ADDR_W:0] addr_s;
  spm_pkg::spm_phase_e phase_r;
  spm_pkg::spm_strap_s strap_r;
  logic mode_r;
  logic pnp_r;
  logic [spm_pkg::BASE_W-1:0] base_r;
  logic [spm_pkg::BASE_W-1:0] strap_base;
  logic [spm_pkg::DRV_W-1:0] drv_nxt;
  logic [spm_pkg::DRV_W-1:0] oe_nxt;
  spm_pkg::spm_core_in_s core_nxt;
  logic stb_nxt;
  logic tc_level;
  logic dack_any;
  logic mb_hit;
  logic [spm_pkg::ADDR_W-1:0] addr_v;
  logic aen_v;
  logic alt_ok;

  // Pin and address synchronisers
  spm_pin_sync #(
    .WIDTH(spm_pkg::PIN_W)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_async(i_pin),
    .o_level(pin_s)
  );

  spm_pin_sync #(
    .WIDTH(spm_pkg::ADDR_W + 1)
  ) u_addr_sync (
    .i_mclk(i_mclk),
    .i_async({i_isa_aen, i_isa_addr}),
    .o_level(addr_s)
  );

  assign addr_v = addr_s[spm_pkg::ADDR_W-1:0];
  assign aen_v = addr_s[spm_pkg::ADDR_W];

  // Startup sequence
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase_r <= spm_pkg::SPM_PH_STRAP;
    end else begin
      case (phase_r)
        spm_pkg::SPM_PH_STRAP: phase_r <= spm_pkg::SPM_PH_LOAD;
        spm_pkg::SPM_PH_LOAD: phase_r <= spm_pkg::SPM_PH_RUN;
        spm_pkg::SPM_PH_RUN: phase_r <= spm_pkg::SPM_PH_RUN;
        default: phase_r <= spm_pkg::SPM_PH_STRAP;
      endcase
    end
  end

  // Strap capture, last level seen while reset is held
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      strap_r.mode_strap <= pin_s[spm_pkg::PIN_MODE];
      strap_r.base_strap_high <= pin_s[spm_pkg::PIN_BASE_HIGH];
      strap_r.base_strap_low <= pin_s[spm_pkg::PIN_BASE_LOW];
    end
  end // Held until next reset

  // Base from straps
  assign strap_base = strap_r.base_strap_low ? spm_pkg::MB_BASE_HIGH
                                             : spm_pkg::MB_BASE_LOW;

  // Mode: strapped, then software may override
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_r <= spm_pkg::MODE_RST;
    end else if (phase_r == spm_pkg::SPM_PH_LOAD) begin
      mode_r <= strap_r.mode_strap;
    end else if (i_mode_load && phase_r == spm_pkg::SPM_PH_RUN) begin
      mode_r <= i_mode_value;
    end
  end

  // Index/data base and full plug-and-play flag
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      base_r <= spm_pkg::BASE_RST;
      pnp_r <= spm_pkg::PNP_RST;
    end else if (phase_r == spm_pkg::SPM_PH_LOAD) begin
      base_r <= strap_base;
      pnp_r <= ~strap_r.mode_strap & ~strap_r.base_strap_high;
    end else if (i_base_load && phase_r == spm_pkg::SPM_PH_RUN) begin
      base_r <= i_base_value;
      pnp_r <= 1'b0;
    end
  end

  // Motherboard decode ignores A0, which picks index or data
  assign mb_hit = ~aen_v && ~addr_v[spm_pkg::ADDR_W-1]
    && (addr_v[spm_pkg::BASE_W-1:1] == base_r[spm_pkg::BASE_W-1:1]);

  // Index and data port hits
  always_ff @(posedge i_mclk) begin
    if (i_rst || phase_r != spm_pkg::SPM_PH_RUN) begin
      o_index_hit <= 1'b0;
      o_data_hit <= 1'b0;
    end else if (pnp_r) begin
      o_index_hit <= ~aen_v && (addr_v == spm_pkg::PNP_INDEX_ADDR);
      o_data_hit <= ~aen_v && (addr_v == spm_pkg::PNP_WDATA_ADDR);
    end else begin
      o_index_hit <= mb_hit && ~addr_v[0];
      o_data_hit <= mb_hit && addr_v[0];
    end
  end

  // Alternates only in second-UART mode
  assign alt_ok = mode_r;

  // Pin drive and enable
  always_comb begin
    drv_nxt = '0;
    oe_nxt = '0;
    if (!mode_r) begin
      // Infrared and misc set
      drv_nxt[spm_pkg::PIN_P94] = 1'b0;
      oe_nxt[spm_pkg::PIN_P94] = ~i_core.keyboard_port_bit;
      drv_nxt[spm_pkg::PIN_P95] = i_core.floppy_rate_select;
      oe_nxt[spm_pkg::PIN_P95] = 1'b1;
      drv_nxt[spm_pkg::PIN_P96] = i_core.infrared_select[2];
      oe_nxt[spm_pkg::PIN_P96] = i_core.infrared_select_oe;
      drv_nxt[spm_pkg::PIN_P97] = i_core.floppy_density_select;
      oe_nxt[spm_pkg::PIN_P97] = 1'b1;
      drv_nxt[spm_pkg::PIN_P98] = i_core.infrared_select[1];
      oe_nxt[spm_pkg::PIN_P98] = i_core.infrared_select_oe;
      drv_nxt[spm_pkg::PIN_P100] = i_core.infrared_select[0];
      oe_nxt[spm_pkg::PIN_P100] = i_core.infrared_select_oe;
    end else begin
      // Second UART set
      drv_nxt[spm_pkg::PIN_P96] = i_core.uart_two_dtr_n;
      oe_nxt[spm_pkg::PIN_P96] = 1'b1;
      drv_nxt[spm_pkg::PIN_P98] = i_core.uart_two_rts_n;
      oe_nxt[spm_pkg::PIN_P98] = 1'b1;
      drv_nxt[spm_pkg::PIN_P100] = i_core.uart_two_serial_out;
      oe_nxt[spm_pkg::PIN_P100] = 1'b1;
    end
    // Pin 43: receive, keyboard bit or rate select
    if (alt_ok && i_pin43_sel == spm_pkg::SEL43_KBD) begin
      drv_nxt[spm_pkg::PIN_P43] = 1'b0;
      oe_nxt[spm_pkg::PIN_P43] = ~i_core.keyboard_port_bit;
    end else if (alt_ok && i_pin43_sel == spm_pkg::SEL43_RATE) begin
      drv_nxt[spm_pkg::PIN_P43] = i_core.floppy_rate_select;
      oe_nxt[spm_pkg::PIN_P43] = 1'b1;
    end
    // Pins 44, 45, 48 are always outputs
    drv_nxt[spm_pkg::PIN_P44] = (alt_ok && i_lower_alt[0])
      ? i_core.floppy_density_select : i_core.infrared_transmit;
    oe_nxt[spm_pkg::PIN_P44] = 1'b1;
    drv_nxt[spm_pkg::PIN_P45] = (alt_ok && i_lower_alt[1])
      ? i_core.floppy_rate_select : i_core.motor_select_zero_n;
    oe_nxt[spm_pkg::PIN_P45] = 1'b1;
    if (alt_ok && i_lower_alt[2]) begin
      drv_nxt[spm_pkg::PIN_P46] = 1'b0;
      oe_nxt[spm_pkg::PIN_P46] = ~i_core.keyboard_port_bit;
    end else begin
      drv_nxt[spm_pkg::PIN_P46] = i_core.motor_select_one_n;
      oe_nxt[spm_pkg::PIN_P46] = 1'b1;
    end
    drv_nxt[spm_pkg::PIN_P48] = (alt_ok && i_lower_alt[3])
      ? i_core.floppy_density_select : i_core.drive_select_one_n;
    oe_nxt[spm_pkg::PIN_P48] = 1'b1;
    // Strap pins serve the first UART once running
    drv_nxt[spm_pkg::PIN_BASE_LOW] = i_core.uart_one_dtr_n;
    drv_nxt[spm_pkg::PIN_BASE_HIGH] = i_core.uart_one_rts_n;
    drv_nxt[spm_pkg::PIN_MODE] = i_core.uart_one_serial_out;
    oe_nxt[spm_pkg::PIN_BASE_LOW] = 1'b1;
    oe_nxt[spm_pkg::PIN_BASE_HIGH] = 1'b1;
    oe_nxt[spm_pkg::PIN_MODE] = 1'b1;
  end

  // Pin registers, all released only when running
  always_ff @(posedge i_mclk) begin
    if (i_rst || phase_r != spm_pkg::SPM_PH_RUN) begin
      o_pin_out <= '0;
      o_pin_oe <= '0; // Strap pins floated while sampled
    end else begin
      o_pin_out <= drv_nxt;
      o_pin_oe <= oe_nxt;
    end
  end

  // Pin levels toward the cores
  always_comb begin
    core_nxt = '1;
    core_nxt.identification_input = '0;
    core_nxt.addr_bit_eleven = 1'b0;
    if (!mode_r) begin
      core_nxt.addr_bit_eleven = pin_s[spm_pkg::PIN_P93];
      core_nxt.keyboard_port_bit = pin_s[spm_pkg::PIN_P94];
      core_nxt.identification_input = {pin_s[spm_pkg::PIN_P99],
        pin_s[spm_pkg::PIN_P96], pin_s[spm_pkg::PIN_P98],
        pin_s[spm_pkg::PIN_P100]};
      core_nxt.infrared_receive_two = pin_s[spm_pkg::PIN_P100];
    end else begin
      core_nxt.uart_two_cts_n = pin_s[spm_pkg::PIN_P93];
      core_nxt.uart_two_dcd_n = pin_s[spm_pkg::PIN_P94];
      core_nxt.uart_two_dsr_n = pin_s[spm_pkg::PIN_P95];
      core_nxt.uart_two_ri_n = pin_s[spm_pkg::PIN_P97];
      core_nxt.uart_two_serial_in = pin_s[spm_pkg::PIN_P99];
      if (i_lower_alt[2]) begin
        core_nxt.keyboard_port_bit = pin_s[spm_pkg::PIN_P46];
      end else if (i_pin43_sel == spm_pkg::SEL43_KBD) begin
        core_nxt.keyboard_port_bit = pin_s[spm_pkg::PIN_P43];
      end
    end
    if (!alt_ok || i_pin43_sel == spm_pkg::SEL43_IRRX) begin
      core_nxt.infrared_receive_one = pin_s[spm_pkg::PIN_P43];
    end
  end

  // Core input register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_core <= '1;
    end else begin
      o_core <= core_nxt;
    end
  end

  // Strobe pin: printer strobe or enhanced write strobe
  assign stb_nxt = i_pp_epp_mode ? i_pp_write_n
                                 : i_pp_stb_n;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pp_stb_pin <= 1'b1;
      o_pp_stb_oe <= 1'b0;
    end else begin
      o_pp_stb_pin <= stb_nxt;
      o_pp_stb_oe <= i_pp_stb_enable; // Floats on 0
    end
  end

  // Busy pin: busy status or enhanced wait
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pp_busy <= 1'b0;
      o_pp_wait_n <= 1'b1;
      o_pp_extend <= 1'b0;
    end else begin
      o_pp_busy <= i_pp_epp_mode ? 1'b0 : pin_s[spm_pkg::PIN_BUSY];
      o_pp_wait_n <= i_pp_epp_mode ? pin_s[spm_pkg::PIN_BUSY] : 1'b1;
      o_pp_extend <= i_pp_epp_mode & ~pin_s[spm_pkg::PIN_BUSY];
    end
  end

  // Terminal count qualification
  assign tc_level = pin_s[spm_pkg::PIN_TC] ^ i_tc_active_low;
  assign dack_any =
    ~&pin_s[spm_pkg::PIN_DACK0 +: spm_pkg::DACK_N]; // Low active

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tc_accepted <= 1'b0;
    end else begin
      o_tc_accepted <= tc_level & dack_any;
    end
  end

  // Configuration state outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_strap <= '0;
      o_mode <= spm_pkg::MODE_RST;
      o_pnp_full <= spm_pkg::PNP_RST;
      o_base <= spm_pkg::BASE_RST;
      o_index_wr_only <= spm_pkg::PNP_RST;
    end else begin
      o_strap <= strap_r;
      o_mode <= mode_r;
      o_pnp_full <= pnp_r;
      o_base <= base_r;
      o_index_wr_only <= pnp_r;
    end
  end

endmodule

`default_nettype wire

// >>> tb/spm_strap_pin_mux_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// Port-level checks on strap capture and pin sharing
module spm_strap_pin_mux_chk (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Pins and cores
  input wire logic [spm_pkg::PIN_W-1:0] i_pin,
  input wire logic [spm_pkg::DRV_W-1:0] o_pin_out,
  input wire logic [spm_pkg::DRV_W-1:0] o_pin_oe,
  input wire spm_pkg::spm_core_out_s i_core,
  // Parallel port and terminal count
  input wire logic i_pp_epp_mode,
  input wire logic i_pp_stb_enable,
  input wire logic i_pp_stb_n,
  input wire logic i_pp_write_n,
  input wire logic o_pp_stb_pin,
  input wire logic o_pp_stb_oe,
  input wire logic o_pp_busy,
  input wire logic o_pp_extend,
  input wire logic i_tc_active_low,
  input wire logic o_tc_accepted,
  // State
  input wire spm_pkg::spm_strap_s o_strap,
  input wire logic o_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Shared serial pin is driven by the first UART once running
  a_sout_pin_owned: assert property (
    $stable(i_core.uart_one_serial_out)[*4] |-> o_pin_oe[15] &&
    o_pin_out[15] == i_core.uart_one_serial_out)
    else $error("shared serial pin not driven by uart");
  // Second UART output on pin 100 in UART mode
  a_uart_two_pin: assert property (
    (o_mode && $stable(i_core.uart_two_serial_out))[*3] |->
    o_pin_oe[7] && o_pin_out[7] == i_core.uart_two_serial_out)
    else $error("pin 100 not carrying uart output");
  // Strobe floats while its control bit is clear
  a_stb_floats: assert property (
    (!i_pp_stb_enable)[*2] |-> !o_pp_stb_oe)
    else $error("strobe driven while disabled");
  // Printer strobe outside enhanced mode
  a_stb_printer: assert property (
    (!i_pp_epp_mode && $stable(i_pp_stb_n))[*4] |->
    o_pp_stb_pin == i_pp_stb_n)
    else $error("printer strobe wrong");
  // Write strobe in enhanced mode
  a_stb_write: assert property (
    (i_pp_epp_mode && $stable(i_pp_write_n))[*4] |->
    o_pp_stb_pin == i_pp_write_n)
    else $error("write strobe wrong");
  // Wait held low stretches the cycle
  a_wait_extends: assert property (
    (i_pp_epp_mode && !i_pin[16])[*8] |-> o_pp_extend)
    else $error("cycle not extended");
  // Busy pin passes through outside enhanced mode
  a_busy_passes: assert property (
    (!i_pp_epp_mode && $stable(i_pin[16]))[*8] |-> o_pp_busy == i_pin[16])
    else $error("busy status wrong");
  // Count ignored with every acknowledge idle
  a_tc_gated: assert property (
    (&i_pin[20:18])[*8] |-> !o_tc_accepted)
    else $error("count accepted without acknowledge");
  // Count polarity follows configuration
  a_tc_polarity: assert property (
    (!i_pin[18] && $stable(i_pin[17]) && $stable(i_tc_active_low))[*8]
    |-> o_tc_accepted == (i_pin[17] ^ i_tc_active_low))
    else $error("count polarity wrong");
  // Captured straps hold while running
  a_strap_held: assert property (
    (!i_rst)[*4] |-> $stable(o_strap))
    else $error("straps changed after reset");
endmodule

bind spm_strap_pin_mux spm_strap_pin_mux_chk i_chk (
  .i_mclk, .i_rst, .i_pin, .o_pin_out, .o_pin_oe, .i_core,
  .i_pp_epp_mode, .i_pp_stb_enable, .i_pp_stb_n, .i_pp_write_n,
  .o_pp_stb_pin, .o_pp_stb_oe, .o_pp_busy, .o_pp_extend,
  .i_tc_active_low, .o_tc_accepted, .o_strap, .o_mode
);
`default_nettype wire

// >>> tb/spm_far_side.sv
`timescale 1ns/10ps
`default_nettype none

// Far side: strap pulls, printer and DMA controller levels
module spm_far_side (
  // Clock
  input wire logic i_mclk,
  // Far-side levels and printer wait length
  input wire logic [spm_pkg::PIN_W-1:0] i_far,
  input wire logic [7:0] i_wait_len,
  // Device drive
  input wire logic [spm_pkg::DRV_W-1:0] i_drv,
  input wire logic [spm_pkg::DRV_W-1:0] i_oe,
  input wire logic i_stb_pin,
  input wire logic i_stb_oe,
  input wire logic i_epp,
  // Resolved lines
  output logic [spm_pkg::PIN_W-1:0] o_pin,
  output logic o_stb_line
);
  logic [7:0] wait_cnt_r = 8'h00;
  logic stb_line_r = 1'b1;

  // Pull-up shows high while the strobe floats
  assign o_stb_line = i_stb_oe ? i_stb_pin : 1'b1;

  // Peripheral holds wait low after each write strobe
  always_ff @(posedge i_mclk) begin
    stb_line_r <= o_stb_line;
    if (i_epp && stb_line_r && !o_stb_line) begin
      wait_cnt_r <= i_wait_len;
    end else if (wait_cnt_r != 8'h00) begin
      wait_cnt_r <= wait_cnt_r - 8'h01;
    end
  end

  // Driven pins show the device, released ones the far level
  always_comb begin
    o_pin = i_far;
    for (int k = 0; k < spm_pkg::DRV_W; k++) begin
      if (i_oe[k]) o_pin[k] = i_drv[k];
    end
    if (wait_cnt_r != 8'h00) o_pin[spm_pkg::PIN_BUSY] = 1'b0;
  end
endmodule
`default_nettype wire

// >>> tb/spm_strap_pin_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none

module spm_strap_pin_mux_tb;
  logic mclk, rst, ml, mv, bl, epp, sen, sn, wn, tcl, aen;
  logic [20:0] far, pin;
  logic [15:0] po, poe;
  logic [10:0] bv, base;
  logic [11:0] addr;
  logic [7:0] wlen;
  logic [3:0] alt;
  logic [1:0] sel43;
  spm_pkg::spm_core_out_s core;
  spm_pkg::spm_core_in_s cin;
  spm_pkg::spm_strap_s strap;
  logic stb, soe, busy, wtn, ext, tca, ih, dh, wro, mode, pnp, line;
  int bad_count, samples_checked;

  spm_strap_pin_mux i_spm_strap_pin_mux (.i_mclk(mclk), .i_rst(rst),
    .i_pin(pin), .o_pin_out(po), .o_pin_oe(poe), .i_core(core),
    .o_core(cin), .i_pin43_sel(sel43), .i_lower_alt(alt),
    .i_mode_load(ml), .i_mode_value(mv), .i_base_load(bl),
    .i_base_value(bv), .i_pp_epp_mode(epp), .i_pp_stb_enable(sen),
    .i_pp_stb_n(sn), .i_pp_write_n(wn), .o_pp_stb_pin(stb),
    .o_pp_stb_oe(soe), .o_pp_busy(busy), .o_pp_wait_n(wtn),
    .o_pp_extend(ext), .i_tc_active_low(tcl), .o_tc_accepted(tca),
    .i_isa_addr(addr), .i_isa_aen(aen), .o_index_hit(ih),
    .o_data_hit(dh), .o_index_wr_only(wro), .o_strap(strap),
    .o_mode(mode), .o_pnp_full(pnp), .o_base(base));
  spm_far_side i_spm_far_side (.i_mclk(mclk), .i_far(far),
    .i_wait_len(wlen), .i_drv(po), .i_oe(poe), .i_stb_pin(stb),
    .i_stb_oe(soe), .i_epp(epp), .o_pin(pin), .o_stb_line(line));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    samples_checked++;
    if (act !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic do_reset(input logic [2:0] s);
    far[15:13] = s;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(6);
  endtask

  task automatic probe(input logic [11:0] a, input logic [1:0] e);
    addr = a;
    cyc(6);
    chk(16'({ih, dh}), 16'(e));
  endtask

  task automatic set_mode(input logic v);
    mv = v;
    ml = 1'b1;
    cyc(1);
    ml = 1'b0;
    cyc(2);
  endtask

  task automatic wait_ext(input logic v);
    int n;
    n = 0;
    while (ext !== v && n < 20) begin
      cyc(1);
      n++;
    end
    if (ext !== v) begin
      bad_count++;
      end_of_test();
    end
  endtask

  task automatic t_straps;
    do_reset(3'b001);
    chk(16'(strap), 16'h0001);
    chk(16'(wro), 16'h0001);
    probe(12'h279, 2'b10);
    probe(12'ha79, 2'b01);
    do_reset(3'b010);
    chk(16'(base), 16'h015c);
    probe(12'h15c, 2'b10);
    probe(12'h15d, 2'b01);
    do_reset(3'b101);
    chk(16'(mode), 16'h0001);
    chk(16'(base), 16'h002e);
    probe(12'h02f, 2'b01);
    probe(12'h82e, 2'b00);
    core.uart_one_serial_out = 1'b0;
    far[15:13] = 3'b010;
    cyc(6);
    chk(16'({poe[15], po[15]}), 16'h0002);
    chk(16'(strap), 16'h0005);
  endtask

  task automatic t_config;
    bv = 11'h100;
    bl = 1'b1;
    cyc(1);
    bl = 1'b0;
    cyc(2);
    chk(16'(pnp), 16'h0000);
    chk(16'(base), 16'h0100);
    probe(12'h100, 2'b10);
    probe(12'h101, 2'b01);
    probe(12'h02e, 2'b00);
    set_mode(1'b0);
    chk(16'(mode), 16'h0000);
  endtask

  task automatic t_pins;
    set_mode(1'b1);
    core.uart_two_serial_out = 1'b0;
    core.motor_select_zero_n = 1'b0;
    far[6] = 1'b0;
    far[0] = 1'b0;
    cyc(6);
    chk(16'({poe[7], po[7]}), 16'h0002);
    chk(16'(cin.uart_two_serial_in), 16'h0000);
    chk(16'(cin.uart_two_cts_n), 16'h0000);
    chk(16'(po[10]), 16'h0000);
    // Every lower alternate selected, pin 43 as rate select
    alt = 4'hf;
    sel43 = spm_pkg::SEL43_RATE;
    cyc(2);
    chk(16'(po[10]), 16'h0001);
    chk(16'({poe[12:8], po[12:8]}), 16'h02f7);
    set_mode(1'b0);
    core.infrared_select = 3'b001;
    far[0] = 1'b1;
    cyc(2);
    chk(16'(po[10]), 16'h0000);
    chk(16'({poe[7], po[7]}), 16'h0003);
    chk(16'({poe[2], po[2]}), 16'h0003);
    chk(16'({poe[12:8], po[12:8]}), 16'h03da);
    // Identification reads back the driven select levels
    cyc(4);
    chk(16'(cin.identification_input), 16'h0001);
    chk(16'(cin.addr_bit_eleven), 16'h0001);
  endtask

  task automatic t_printer;
    cyc(2);
    chk(16'({soe, line}), 16'h0001);
    sen = 1'b1;
    sn = 1'b0;
    cyc(6);
    chk(16'({soe, stb, busy, wtn}), 16'h000b);
    epp = 1'b1;
    cyc(6);
    chk(16'({stb, busy, wtn}), 16'h0005);
    wn = 1'b0;
    wait_ext(1'b1);
    chk(16'({stb, wtn}), 16'h0000);
    wait_ext(1'b0);
    chk(16'({pin[16], wtn}), 16'h0003);
    wn = 1'b1;
    epp = 1'b0;
  endtask

  task automatic t_tc;
    for (int i = 0; i < 8; i++) begin
      tcl = i[0];
      far[17] = i[1];
      far[18] = !i[2];
      cyc(6);
      chk(16'(tca), 16'(i[2] & (i[1] ^ i[0])));
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    far = '1;
    core = '1;
    core.infrared_select_oe = 1'b1;
    {ml, mv, bl, epp, sen, tcl, aen} = '0;
    {sn, wn} = 2'b11;
    bv = 11'h000;
    addr = 12'h000;
    wlen = 8'h0c;
    alt = 4'h0;
    sel43 = 2'h0;
    cyc(1);
    t_straps();
    t_config();
    t_pins();
    t_printer();
    t_tc();
    end_of_test();
  end
endmodule
`default_nettype wire
